// >>> crm_alu.sv
// Purpose: combinational result and flag generator
// Assumes: operand and accumulator valid in same cycle
// Notes:   flags only updated where the op defines them
`timescale 1ns/1ps
`include "crm_cfg.svh"
module crm_alu
   import crm_pkg::*;
(
   input  wire crm_alu_req_s req,
   input  wire logic [7:0]   acc,
   input  wire logic         carry_in,
   output crm_alu_res_s      res
);
   logic [8:0] wide;
   always_comb begin
      wide = 9'h000;
      res  = '0;
      case (req.op)
         CRM_OP_LOAD, CRM_OP_MOVE: begin
            res.result = req.operand;
            res.upd_z  = 1'b1;
            res.wr_acc = (req.op == CRM_OP_LOAD) && !req.mem_dst;
         end
         CRM_OP_STORE: begin
            res.result = acc;
            res.upd_z  = 1'b1;
         end
         CRM_OP_ADD: begin
            wide       = {1'b0, acc} + {1'b0, req.operand};
            res.result = wide[7:0];
            // same as both-msb or one-msb-and-result-below-half
            res.carry  = (acc[7] & req.operand[7]) |
                         ((acc[7] | req.operand[7]) & ~wide[7]);
            res.upd_z  = 1'b1;
            res.upd_c  = 1'b1;
            res.wr_acc = 1'b1;
         end
         CRM_OP_SUB, CRM_OP_CMP: begin
            wide       = {1'b0, acc} - {1'b0, req.operand};
            res.result = wide[7:0];
            res.carry  = req.operand > acc;
            res.upd_z  = 1'b1;
            res.upd_c  = 1'b1;
            res.wr_acc = (req.op == CRM_OP_SUB);
         end
         CRM_OP_AND, CRM_OP_OR, CRM_OP_XOR: begin
            res.result = (req.op == CRM_OP_AND) ? (acc & req.operand) :
                         (req.op == CRM_OP_OR)  ? (acc | req.operand) :
                                                  (acc ^ req.operand);
            res.upd_z  = 1'b1;
            res.wr_acc = 1'b1;
         end
         CRM_OP_INC, CRM_OP_DEC: begin
            res.result = (req.op == CRM_OP_INC) ? req.operand + 8'h01
                                                : req.operand - 8'h01;
            res.upd_z  = 1'b1;
            res.wr_acc = !req.mem_dst;
         end
         CRM_OP_LSL, CRM_OP_ROL: begin
            // 9-bit shift through carry
            res.result = {req.operand[6:0], (req.op == CRM_OP_ROL) & carry_in};
            res.carry  = req.operand[7];
            res.upd_z  = 1'b1;
            res.upd_c  = 1'b1;
            res.wr_acc = !req.mem_dst;
         end
         CRM_OP_LSR, CRM_OP_ROR: begin
            res.result = {(req.op == CRM_OP_ROR) & carry_in, req.operand[7:1]};
            res.carry  = req.operand[0];
            res.upd_z  = 1'b1;
            res.upd_c  = 1'b1;
            res.wr_acc = !req.mem_dst;
         end
         CRM_OP_SEC, CRM_OP_CLC: begin
            res.carry  = (req.op == CRM_OP_SEC);
            res.upd_c  = 1'b1;
         end
         CRM_OP_BITTEST: begin
            res.carry  = req.operand[0];
            res.upd_c  = 1'b1;
         end
         default: begin
            res = '0;
         end
      endcase
      res.zero = (res.result == `CRM_ACC_RST);
   end
endmodule

// >>> crm_cfg.svh
// Purpose: constants for the core register model
// Assumes: 14-bit address space, 8-bit data
// Notes:   included by the modules other than the memory model, not by the package
`ifndef CRM_CFG_SVH
`define CRM_CFG_SVH
`define CRM_START_ADDR   14'h3ffd
`define CRM_ACC_RST      8'h00
`define CRM_HALF_RANGE   8'h80
`define CRM_ADDR_IDATA   14'h000e
`define CRM_ADDR_INDEX   14'h000f
`define CRM_ADDR_PAGE    14'h001f
`define CRM_WIN_LO       14'h00c0
`define CRM_WIN_HI       14'h00ff
`define CRM_IDX_RST      8'h00
`define CRM_PAGE_RST     8'h00
`define CRM_FLAGS_RST    2'h0
`define CRM_FLAG_Z       1
`define CRM_FLAG_C       0
`endif

// >>> crm_core_regs.sv
// Purpose: programmer-visible registers of a small 8-bit core
// Assumes: sequencer presents one micro-op per enabled cycle
// Notes:   addressing-mode decode lives in the sequencer
`timescale 1ns/1ps
`include "crm_cfg.svh"
module crm_core_regs
   import crm_pkg::*;
(
   input  wire logic         CLOCK,
   input  wire logic         RESET,
   input  wire logic         CLK_EN,
   input  wire logic         FETCH,
   input  wire logic         PC_LOAD,
   input  wire logic [13:0]  PC_TARGET,
   input  wire logic         CALL,
   input  wire logic         RETURN,
   input  wire crm_br_e      BR_COND,
   input  wire logic [13:0]  BR_TARGET,
   input  wire crm_alu_req_s ALU_REQ,
   input  wire logic [13:0]  MEM_ADDR,
   input  wire logic         MEM_RD,
   input  wire logic         MEM_WR,
   input  wire logic [7:0]   MEM_WDATA,
   input  wire logic         DBG_FLAG_WR,
   input  wire logic [1:0]   DBG_FLAG_DATA,
   output logic [7:0]        ACC,
   output logic [13:0]       PC,
   output logic [13:0]       RETURN_HOLDER,
   output logic [1:0]        DBG_FLAGS,
   output logic              BR_TAKEN,
   output crm_mem_s          BUS_OUT,
   output logic [7:0]        REG_RDATA,
   output logic              REG_HIT,
   output logic [7:0]        PAGE_SEL,
   output logic [7:0]        INDEX
);
   crm_state_e   state_r;
   logic [7:0]   acc_r;
   logic [13:0]  pc_r;
   logic [13:0]  ret_r;
   logic [1:0]   condition_flags_r;
   logic [7:0]   index_pointer_r;
   logic [7:0]   page_window_select_r;
   crm_alu_res_s alu_res;
   logic         take_nxt;
   crm_mem_s     bus_nxt;
   logic [7:0]   rdata_nxt;
   logic         hit_nxt;
   logic [13:0]  pc_seq;

   function automatic logic is_addr(input logic [13:0] a, input logic [13:0] ref_a);
      is_addr = (a == ref_a);
   endfunction

   function automatic logic in_window(input logic [13:0] a);
      in_window = (a >= `CRM_WIN_LO) && (a <= `CRM_WIN_HI);
   endfunction

   // a conditional branch only counts when a condition is given and it holds
   function automatic logic br_fires(input crm_br_e c, input logic t);
      br_fires = (c != CRM_BR_NONE) && t;
   endfunction

   // swap decode is shared by the accumulator and the return holder
   function automatic logic is_op(input crm_op_e o, input crm_op_e want);
      is_op = (o == want);
   endfunction

   crm_alu u_alu (
      .req      (ALU_REQ),
      .acc      (acc_r),
      .carry_in (condition_flags_r[`CRM_FLAG_C]),
      .res      (alu_res)
   );

   // branch decision looks at one flag at most; flags never reach the data bus
   always_comb begin
      case (BR_COND)
         CRM_BR_ZERO:   take_nxt = condition_flags_r[`CRM_FLAG_Z];
         CRM_BR_NZERO:  take_nxt = !condition_flags_r[`CRM_FLAG_Z];
         CRM_BR_CCLR:   take_nxt = !condition_flags_r[`CRM_FLAG_C];
         CRM_BR_CSET:   take_nxt = condition_flags_r[`CRM_FLAG_C];
         CRM_BR_ALWAYS: take_nxt = 1'b1;
         default:       take_nxt = 1'b0;
      endcase
   end

   assign pc_seq = pc_r + 14'h0001;

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         state_r <= CRM_ST_RESET;
      end else if (CLK_EN) begin
         state_r <= CRM_ST_RUN;
      end
   end

   // accumulator
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         acc_r <= `CRM_ACC_RST;
      end else if (CLK_EN) begin
         // both halves of a swap move on one edge, so no temporary is needed
         if (is_op(ALU_REQ.op, CRM_OP_SWAP_HI)) begin
            acc_r <= {2'b00, ret_r[13:8]};
         end else if (is_op(ALU_REQ.op, CRM_OP_SWAP_LO)) begin
            acc_r <= ret_r[7:0];
         end else if (alu_res.wr_acc) begin
            acc_r <= alu_res.result;
         end
      end
   end

   // program counter; change-of-flow wins over sequential advance
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         pc_r <= `CRM_START_ADDR;
      end else if (CLK_EN) begin
         if (RETURN) begin
            pc_r <= ret_r;
         end else if (PC_LOAD) begin
            pc_r <= PC_TARGET;
         end else if (br_fires(BR_COND, take_nxt)) begin
            pc_r <= BR_TARGET;
         end else if (FETCH) begin
            pc_r <= pc_seq;
         end
      end
   end

   // return holder; sequencer presents PC already past the call
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         ret_r <= `CRM_START_ADDR;
      end else if (CLK_EN) begin
         if (CALL) begin
            ret_r <= pc_r;
         end else if (is_op(ALU_REQ.op, CRM_OP_SWAP_HI)) begin
            ret_r[13:8] <= acc_r[5:0];
         end else if (is_op(ALU_REQ.op, CRM_OP_SWAP_LO)) begin
            ret_r[7:0] <= acc_r;
         end
      end
   end

   // flags: only the debug port writes them directly
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         condition_flags_r <= `CRM_FLAGS_RST;
      end else if (CLK_EN) begin
         if (DBG_FLAG_WR) begin
            condition_flags_r <= DBG_FLAG_DATA;
         end else begin
            if (alu_res.upd_z) begin
               condition_flags_r[`CRM_FLAG_Z] <= alu_res.zero;
            end
            if (alu_res.upd_c) begin
               condition_flags_r[`CRM_FLAG_C] <= alu_res.carry;
            end
         end
      end
   end

   // memory-mapped index and page registers
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         index_pointer_r      <= `CRM_IDX_RST;
         page_window_select_r <= `CRM_PAGE_RST;
      end else if (CLK_EN && MEM_WR) begin
         if (is_addr(MEM_ADDR, `CRM_ADDR_INDEX)) begin
            index_pointer_r <= MEM_WDATA;
         end
         if (is_addr(MEM_ADDR, `CRM_ADDR_PAGE)) begin
            page_window_select_r <= MEM_WDATA;
         end
      end
   end

   // address translation onto the memory bus
   always_comb begin
      bus_nxt   = '0;
      rdata_nxt = 8'h00;
      hit_nxt   = 1'b0;
      if (MEM_RD || MEM_WR) begin
         bus_nxt.valid = 1'b1;
         bus_nxt.write = MEM_WR;
         bus_nxt.wdata = MEM_WDATA;
         bus_nxt.addr  = MEM_ADDR;
         if (is_addr(MEM_ADDR, `CRM_ADDR_IDATA)) begin
            bus_nxt.addr = {6'h00, index_pointer_r};
         end else if (is_addr(MEM_ADDR, `CRM_ADDR_INDEX)) begin
            bus_nxt.valid = 1'b0;
            hit_nxt       = MEM_RD;
            rdata_nxt     = index_pointer_r;
         end else if (is_addr(MEM_ADDR, `CRM_ADDR_PAGE)) begin
            bus_nxt.valid = 1'b0;
            hit_nxt       = MEM_RD;
            rdata_nxt     = page_window_select_r;
         end else if (in_window(MEM_ADDR)) begin
            // 64-byte window; 8 page bits and 6 offset bits span the whole 14-bit space
            bus_nxt.addr = {page_window_select_r, MEM_ADDR[5:0]};
         end
      end
   end

   // registered outputs
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         BUS_OUT   <= '0;
         REG_RDATA <= 8'h00;
         REG_HIT   <= 1'b0;
         BR_TAKEN  <= 1'b0;
      end else if (CLK_EN) begin
         BUS_OUT   <= bus_nxt;
         REG_RDATA <= rdata_nxt;
         REG_HIT   <= hit_nxt;
         BR_TAKEN  <= br_fires(BR_COND, take_nxt);
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         ACC           <= `CRM_ACC_RST;
         PC            <= `CRM_START_ADDR;
         RETURN_HOLDER <= `CRM_START_ADDR;
         DBG_FLAGS     <= `CRM_FLAGS_RST;
         PAGE_SEL      <= `CRM_PAGE_RST;
         INDEX         <= `CRM_IDX_RST;
      end else if (CLK_EN) begin
         ACC           <= acc_r;
         PC            <= pc_r;
         RETURN_HOLDER <= ret_r;
         DBG_FLAGS     <= condition_flags_r;
         PAGE_SEL      <= page_window_select_r;
         INDEX         <= index_pointer_r;
      end
   end
endmodule

// >>> crm_core_regs_assertions.sv
// Purpose: port checks for the core register block
// Assumes: mirrors lag internal state by one enabled edge
// Notes:   bound to every crm_core_regs instance
`timescale 1ns/1ps
`include "crm_cfg.svh"
module crm_core_regs_assertions
   import crm_pkg::*;
(
   input wire logic         CLOCK,
   input wire logic         RESET,
   input wire logic         CLK_EN,
   input wire logic         FETCH,
   input wire logic         PC_LOAD,
   input wire logic [13:0]  PC_TARGET,
   input wire logic         RETURN,
   input wire crm_br_e      BR_COND,
   input wire crm_alu_req_s ALU_REQ,
   input wire logic [13:0]  MEM_ADDR,
   input wire logic         MEM_RD,
   input wire logic         MEM_WR,
   input wire logic         DBG_FLAG_WR,
   input wire logic [1:0]   DBG_FLAG_DATA,
   input wire logic [7:0]   ACC,
   input wire logic [13:0]  PC,
   input wire logic [13:0]  RETURN_HOLDER,
   input wire logic [1:0]   DBG_FLAGS,
   input wire logic         BR_TAKEN,
   input wire crm_mem_s     BUS_OUT,
   input wire logic         REG_HIT,
   input wire logic [7:0]   INDEX
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RESET);
   // the second enabled edge is needed before a mirror shows the change
   sequence s_fetch;
      CLK_EN && FETCH && !RETURN && !PC_LOAD && BR_COND == CRM_BR_NONE ##1 CLK_EN;
   endsequence
   sequence s_add;
      CLK_EN && ALU_REQ.op == CRM_OP_ADD && !ALU_REQ.mem_dst && !DBG_FLAG_WR ##1 CLK_EN;
   endsequence
   property p_rst;
      $fell(RESET) |-> ACC == `CRM_ACC_RST && DBG_FLAGS == `CRM_FLAGS_RST
         && PC == `CRM_START_ADDR
         && RETURN_HOLDER == `CRM_START_ADDR;
   endproperty
   property p_fetch;
      s_fetch |=> PC == $past(PC) + 14'h1;
   endproperty
   property p_load;
      CLK_EN && PC_LOAD && !RETURN ##1 CLK_EN |=> PC == $past(PC_TARGET, 2);
   endproperty
   property p_ret;
      CLK_EN && RETURN ##1 CLK_EN |=> PC == $past(RETURN_HOLDER);
   endproperty
   property p_brz;
      CLK_EN && BR_COND == CRM_BR_ZERO |=> BR_TAKEN == DBG_FLAGS[`CRM_FLAG_Z];
   endproperty
   property p_brc;
      CLK_EN && BR_COND == CRM_BR_CSET |=> BR_TAKEN == DBG_FLAGS[`CRM_FLAG_C];
   endproperty
   property p_add;
      s_add |=> {DBG_FLAGS[0], ACC} == {1'h0, $past(ACC)} + {1'h0, $past(ALU_REQ.operand, 2)};
   endproperty
   property p_sec;
      CLK_EN && ALU_REQ.op == CRM_OP_SEC && !DBG_FLAG_WR ##1 CLK_EN |=> DBG_FLAGS[0];
   endproperty
   property p_dbg;
      CLK_EN && DBG_FLAG_WR ##1 CLK_EN |=> DBG_FLAGS == $past(DBG_FLAG_DATA, 2);
   endproperty
   property p_hit;
      CLK_EN && MEM_RD && MEM_ADDR == `CRM_ADDR_INDEX |=> REG_HIT && !BUS_OUT.valid;
   endproperty
   property p_idx;
      CLK_EN && (MEM_RD || MEM_WR) && MEM_ADDR == `CRM_ADDR_IDATA
         |=> BUS_OUT.valid && BUS_OUT.addr == {6'h00, INDEX};
   endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   a_fetch: assert property (p_fetch) else $error("pc did not advance");
   a_load: assert property (p_load) else $error("pc load lost");
   a_ret: assert property (p_ret) else $error("return target wrong");
   a_brz: assert property (p_brz) else $error("zero branch wrong");
   a_brc: assert property (p_brc) else $error("carry branch wrong");
   a_add: assert property (p_add) else $error("add result wrong");
   a_sec: assert property (p_sec) else $error("carry not set");
   a_dbg: assert property (p_dbg) else $error("debug flag write lost");
   a_hit: assert property (p_hit) else $error("index read not local");
   a_idx: assert property (p_idx) else $error("indexed address wrong");
endmodule
bind crm_core_regs crm_core_regs_assertions u_chk (.*);

// >>> crm_core_regs_tb_top.sv
// Purpose: directed bench for the core register block
// Assumes: ops issued one at a time, outputs read after mirrors settle
// Notes:   flags read as {zero, carry}
`timescale 1ns/1ps
`include "crm_cfg.svh"
module crm_core_regs_tb_top import crm_pkg::*;;
   logic         clock, reset, clk_en, fetch, pc_load, call, ret;
   logic         dbg_wr, mem_rd, mem_wr, taken, hit;
   logic [13:0]  pc_tgt, br_tgt, mem_addr, pc, holder;
   logic [7:0]   wdata, acc, rdata, page, index;
   logic [1:0]   dbg_data, flags;
   crm_br_e      br;
   crm_alu_req_s req;
   crm_mem_s     bus;
   int           n_mismatch = 0;
   int           tests_run = 0;
   int           cyc = 0;
   crm_core_regs u_dut (.CLOCK(clock), .RESET(reset), .CLK_EN(clk_en), .FETCH(fetch),
      .PC_LOAD(pc_load), .PC_TARGET(pc_tgt), .CALL(call), .RETURN(ret), .BR_COND(br),
      .BR_TARGET(br_tgt), .ALU_REQ(req), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd),
      .MEM_WR(mem_wr), .MEM_WDATA(wdata), .DBG_FLAG_WR(dbg_wr), .DBG_FLAG_DATA(dbg_data),
      .ACC(acc), .PC(pc), .RETURN_HOLDER(holder), .DBG_FLAGS(flags), .BR_TAKEN(taken),
      .BUS_OUT(bus), .REG_RDATA(rdata), .REG_HIT(hit), .PAGE_SEL(page), .INDEX(index));
   crm_mem_model u_mem (.CLOCK(clock), .BUS(bus));
   always #10 clock = ~clock;
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task clr;
      fetch <= 1'h0;
      pc_load <= 1'h0;
      call <= 1'h0;
      ret <= 1'h0;
      dbg_wr <= 1'h0;
      mem_rd <= 1'h0;
      mem_wr <= 1'h0;
      br <= CRM_BR_NONE;
      req <= '0;
   endtask
   // one-edge outputs are valid after go, mirrored state after late
   task go;
      @(posedge clock);
      clr();
      #1;
   endtask
   task late;
      @(posedge clock);
      #1;
   endtask
   task rst_chk;
      chk(acc, 8'h00);
      chk(pc, `CRM_START_ADDR);
      chk(holder, `CRM_START_ADDR);
      chk(flags, 2'h0);
      chk(index, 8'h00);
      chk(page, 8'h00);
   endtask
   task alu(input crm_op_e o, input logic [7:0] v, input logic [7:0] ea, input logic [1:0] ef);
      @(posedge clock);
      req <= '{o, 1'h0, v};
      go();
      late();
      chk(acc, ea);
      chk(flags, ef);
   endtask
   task brc(input crm_br_e c, input logic [13:0] t, input logic tk);
      logic [13:0] p0;
      p0 = pc;
      @(posedge clock);
      br <= c;
      br_tgt <= t;
      go();
      chk(taken, tk);
      late();
      chk(pc, tk ? t : p0);
   endtask
   task setpc(input logic [13:0] t);
      @(posedge clock);
      pc_load <= 1'h1;
      pc_tgt <= t;
      go();
      late();
   endtask
   task mem(input logic w, input logic [13:0] a, input logic [7:0] d);
      @(posedge clock);
      mem_wr <= w;
      mem_rd <= !w;
      mem_addr <= a;
      wdata <= d;
      go();
   endtask
   task test_done;
      $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // the whole run needs under 150 cycles
   always @(posedge clock) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         test_done();
      end
   end
   initial begin
      clock = 1'h0;
      reset = 1'h1;
      clk_en = 1'h1;
      pc_tgt = 14'h0000;
      br_tgt = 14'h0000;
      mem_addr = 14'h0000;
      wdata = 8'h00;
      dbg_data = 2'h0;
      clr();
      repeat (8) @(posedge clock);
      reset <= 1'h0;
      #1;
      rst_chk();
      $display("test reset done");
      // inherent shifts and inc/dec take the accumulator as operand, as the sequencer does
      alu(CRM_OP_LOAD, 8'h80, 8'h80, 2'h0);
      alu(CRM_OP_ADD, 8'h80, 8'h00, 2'h3);
      alu(CRM_OP_LOAD, 8'h05, 8'h05, 2'h1);
      alu(CRM_OP_SUB, 8'h07, 8'hfe, 2'h1);
      alu(CRM_OP_CMP, 8'hfe, 8'hfe, 2'h2);
      alu(CRM_OP_SEC, 8'h00, 8'hfe, 2'h3);
      alu(CRM_OP_ROL, 8'hfe, 8'hfd, 2'h1);
      alu(CRM_OP_LSR, 8'hfd, 8'h7e, 2'h1);
      alu(CRM_OP_CLC, 8'h00, 8'h7e, 2'h0);
      alu(CRM_OP_ROR, 8'h7e, 8'h3f, 2'h0);
      alu(CRM_OP_LSL, 8'h3f, 8'h7e, 2'h0);
      alu(CRM_OP_BITTEST, 8'h01, 8'h7e, 2'h1);
      alu(CRM_OP_INC, 8'h7e, 8'h7f, 2'h1);
      alu(CRM_OP_AND, 8'h0c, 8'h0c, 2'h1);
      alu(CRM_OP_OR, 8'h30, 8'h3c, 2'h1);
      alu(CRM_OP_XOR, 8'h3c, 8'h00, 2'h3);
      alu(CRM_OP_DEC, 8'h00, 8'hff, 2'h1);
      alu(CRM_OP_STORE, 8'h55, 8'hff, 2'h1);
      alu(CRM_OP_LOAD, 8'h00, 8'h00, 2'h3);
      $display("test alu done");
      brc(CRM_BR_ZERO, 14'h0100, 1'h1);
      brc(CRM_BR_NZERO, 14'h0200, 1'h0);
      brc(CRM_BR_CSET, 14'h0300, 1'h1);
      brc(CRM_BR_CCLR, 14'h0400, 1'h0);
      brc(CRM_BR_ALWAYS, 14'h0500, 1'h1);
      @(posedge clock);
      dbg_wr <= 1'h1;
      dbg_data <= 2'h0;
      go();
      late();
      chk(flags, 2'h0);
      brc(CRM_BR_ZERO, 14'h0600, 1'h0);
      brc(CRM_BR_CCLR, 14'h0700, 1'h1);
      chk(flags, 2'h0);
      $display("test branch done");
      setpc(14'h2abc);
      chk(pc, 14'h2abc);
      @(posedge clock);
      fetch <= 1'h1;
      @(posedge clock);
      go();
      late();
      chk(pc, 14'h2abe);
      @(posedge clock);
      call <= 1'h1;
      go();
      late();
      chk(holder, 14'h2abe);
      setpc(14'h0040);
      @(posedge clock);
      ret <= 1'h1;
      go();
      late();
      chk(pc, 14'h2abe);
      alu(CRM_OP_SWAP_LO, 8'h00, 8'hbe, 2'h0);
      chk(holder, 14'h2a00);
      alu(CRM_OP_SWAP_HI, 8'h00, 8'h2a, 2'h0);
      chk(holder, 14'h3e00);
      $display("test flow done");
      mem(1'h1, 14'h000f, 8'h3a);
      late();
      chk(index, 8'h3a);
      mem(1'h0, 14'h000f, 8'h00);
      chk({hit, bus.valid, rdata}, {2'h2, 8'h3a});
      mem(1'h1, 14'h001f, 8'h9c);
      late();
      chk(page, 8'h9c);
      mem(1'h0, 14'h001f, 8'h00);
      chk({hit, rdata}, {1'h1, 8'h9c});
      mem(1'h1, 14'h000e, 8'h77);
      chk(bus, {2'h3, 14'h003a, 8'h77});
      late();
      chk(u_mem.mem[14'h003a], 8'h77);
      mem(1'h0, 14'h00c5, 8'h00);
      chk(bus.addr, {8'h9c, 6'h05});
      mem(1'h0, 14'h0123, 8'h00);
      chk(bus.addr, 14'h0123);
      $display("test registers done");
      @(posedge clock);
      clk_en <= 1'h0;
      fetch <= 1'h1;
      repeat (3) @(posedge clock);
      clr();
      clk_en <= 1'h1;
      late();
      late();
      chk(pc, 14'h2abe);
      @(posedge clock);
      reset <= 1'h1;
      repeat (2) @(posedge clock);
      reset <= 1'h0;
      #1;
      rst_chk();
      $display("test freeze and reset done");
      test_done();
   end
endmodule

// >>> crm_mem_model.sv
// Purpose: memory bus stand-in behind the core register block
// Assumes: one access per cycle, writes land at the edge
// Notes:   no read path; the block takes no read data
`timescale 1ns/1ps
module crm_mem_model
   import crm_pkg::*;
(
   input wire logic     CLOCK,
   input wire crm_mem_s BUS
);
   logic [7:0] mem [0:16383];
   always_ff @(posedge CLOCK) begin
      if (BUS.valid && BUS.write) begin
         mem[BUS.addr] <= BUS.wdata;
      end
   end
endmodule

// >>> crm_pkg.sv
// Purpose: types for the core register model
// Assumes: crm_cfg.svh constants
// Notes:   op codes are internal micro-operation selects
package crm_pkg;
   typedef enum logic [4:0] {
      CRM_OP_NONE       = 5'h00,
      CRM_OP_LOAD       = 5'h01,
      CRM_OP_STORE      = 5'h02,
      CRM_OP_MOVE       = 5'h03,
      CRM_OP_ADD        = 5'h04,
      CRM_OP_SUB        = 5'h05,
      CRM_OP_CMP        = 5'h06,
      CRM_OP_AND        = 5'h07,
      CRM_OP_OR         = 5'h08,
      CRM_OP_XOR        = 5'h09,
      CRM_OP_INC        = 5'h0a,
      CRM_OP_DEC        = 5'h0b,
      CRM_OP_LSL        = 5'h0c,
      CRM_OP_LSR        = 5'h0d,
      CRM_OP_ROL        = 5'h0e,
      CRM_OP_ROR        = 5'h0f,
      CRM_OP_SEC        = 5'h10,
      CRM_OP_CLC        = 5'h11,
      CRM_OP_BITTEST    = 5'h12,
      CRM_OP_SWAP_HI    = 5'h13,
      CRM_OP_SWAP_LO    = 5'h14
   } crm_op_e;
   typedef enum logic [2:0] {
      CRM_BR_NONE  = 3'h0,
      CRM_BR_ZERO  = 3'h1,
      CRM_BR_NZERO = 3'h2,
      CRM_BR_CCLR  = 3'h3,
      CRM_BR_CSET  = 3'h4,
      CRM_BR_ALWAYS = 3'h5
   } crm_br_e;
   typedef enum logic [1:0] {
      CRM_ST_RESET = 2'b00,
      CRM_ST_RUN   = 2'b01
   } crm_state_e;
   typedef struct packed {
      crm_op_e     op;
      logic        mem_dst;
      logic [7:0]  operand;
   } crm_alu_req_s;
   typedef struct packed {
      logic [7:0]  result;
      logic        zero;
      logic        carry;
      logic        upd_z;
      logic        upd_c;
      logic        wr_acc;
   } crm_alu_res_s;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [13:0] addr;
      logic [7:0]  wdata;
   } crm_mem_s;
endpackage
